// >>> chan_sink.sv
// Datapath model taking the appended checksum word after a stall
module chan_sink (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic [3:0]         stall,
  input  wire logic               post_valid,
  input  wire dma_crc_pkg::word_t post_data,
  output logic                    post_ready,
  output dma_crc_pkg::word_t      got,
  output int                      n
);
  import dma_crc_pkg::*;
  logic [3:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_ready <= 1'h0;
      cnt_r <= 4'h0;
      got <= '0;
      n <= 0;
    end else if (post_valid && post_ready) begin
      got <= post_data;
      n <= n + 1;
      post_ready <= 1'h0;
    end else if (post_valid) begin
      post_ready <= (cnt_r == stall);
      cnt_r <= cnt_r + 4'h1;
    end else begin
      post_ready <= 1'h0;
      cnt_r <= 4'h0;
    end
  end
endmodule : chan_sink

// >>> crc32_engine.sv
// Word-wide CRC-32 generator, data taken least significant bit first
`include "dma_crc_params.svh"

module crc32_engine (
  input  wire logic hclk,
  input  wire logic hresetn,
  crc_if.engine     crc
);
  import dma_crc_pkg::*;

  // ========================================================================
  // One 32-bit word folded into the generator state
  function automatic word_t crc_step(input word_t cur, input word_t data);
    word_t c;
    c = cur;
    for (int i = 0; i < `DATA_W; i++) begin
      if (c[`DATA_W-1] ^ data[i]) begin
        c = {c[`DATA_W-2:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[`DATA_W-2:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_step

  word_t state_r;

  // ========================================================================
  // State: load wins over accumulation, kept between transactions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= `RST_CRC;
    end else if (crc.load) begin
      state_r <= crc.load_value;
    end else if (crc.step) begin
      state_r <= crc_step(state_r, crc.word);
    end
  end

  assign crc.state = state_r;

endmodule : crc32_engine

// >>> crc_if.sv
// Link between the register block and the checksum generator
interface crc_if;
  import dma_crc_pkg::*;

  logic  load;
  word_t load_value;
  logic  step;
  word_t word;
  word_t state;

  modport engine (
    input  load,
    input  load_value,
    input  step,
    input  word,
    output state
  );

  modport user (
    output load,
    output load_value,
    output step,
    output word,
    input  state
  );
endinterface : crc_if

// >>> dma_channel_crc_and_irq_enable.sv
// Channel interrupt enables, status flags and CRC-32 unit behind an AHB-Lite slave
// Functional notes
// - Bit 2 enables completion interrupt
// - Bit 1 enables flow overflow interrupt
// - Bit 0 enables bus fault interrupt
// - Append CRC after normal completion when enabled
// - No append after abort or bus error
// - No append when peripheral ended transaction
// - Bit 0 turns CRC accumulation on
// - Checksum write loads generator start state
// - Checksum read is reversed and inverted
// - Generator state kept across transactions
// - Done flag only on address limit
// - CRC done set at end, cleared on start
//
// Our own choice: the AHB-Lite register port.
`include "dma_crc_params.svh"

module dma_channel_crc_and_irq_enable (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire dma_crc_pkg::addr_t   haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire dma_crc_pkg::word_t   hwdata,
  input  wire logic                 hready,
  output      logic                 hreadyout,
  output      logic                 hresp,
  output      dma_crc_pkg::word_t   hrdata,
  // Channel datapath
  input  wire logic                 xfer_start,
  input  wire logic                 data_valid,
  input  wire dma_crc_pkg::word_t   data_word,
  input  wire logic                 end_limit,
  input  wire logic                 end_periph_term,
  input  wire logic                 end_fw_abort,
  input  wire logic                 bus_error,
  input  wire logic                 flow_overflow,
  // Checksum append transfer
  output      logic                 post_valid,
  output      dma_crc_pkg::word_t   post_data,
  input  wire logic                 post_ready,
  // Channel interrupt
  output      logic                 irq
);
  import dma_crc_pkg::*;

  // ========================================================================
  // Bit order reversal
  function automatic word_t bit_reverse(input word_t v);
    word_t r;
    r = '0;
    for (int i = 0; i < `DATA_W; i++) begin
      r[i] = v[`DATA_W-1-i];
    end
    return r;
  endfunction : bit_reverse

  // ========================================================================
  // Write strobe for one register offset
  function automatic logic reg_hit(input logic en, input addr_t at, input addr_t ofs);
    return en && (at == ofs);
  endfunction : reg_hit

  // ========================================================================
  // Declarations
  logic                       dp_act_r;
  logic                       dp_write_r;
  addr_t                      dp_addr_r;
  logic                       rd_wait_r;
  word_t                      hrdata_r;
  logic                       wr_en;
  logic [`IRQ_W-1:0]          irq_status_r;
  logic [`IRQ_W-1:0]          irq_status_nxt;
  logic [`IRQ_W-1:0]          irq_set;
  logic [`IRQ_W-1:0]          irq_mask_r;
  logic [`CTL_W-1:0]          ctl_r;
  logic [`PST_W-1:0]          pst_r;
  logic [`PST_W-1:0]          pst_nxt;
  post_state_e                post_state_r;
  word_t                      post_data_r;
  logic                       xfer_end;
  logic                       post_go;
  logic                       post_fin;
  word_t                      crc_out;
  word_t                      rd_mux;
  logic                       rd_first;
  logic                       wr_status;
  logic                       wr_mask;
  logic                       wr_ctl;
  logic                       wr_crc;
  logic                       post_start;
  logic [`IRQ_W-1:0]          irq_pend;
  logic [`PST_W-1:0]          pst_set;
  logic [`PST_W-1:0]          pst_clr;

  crc_if crc ();

  crc32_engine u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .crc     (crc)
  );

  // ========================================================================
  // AHB-Lite address and data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_r   <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= '0;
    end else if (hready) begin
      dp_act_r   <= hsel & htrans[1];
      dp_write_r <= hwrite;
      dp_addr_r  <= haddr;
    end
  end

  // Reads take one wait state so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= rd_first;
    end
  end

  // First data cycle of a read stalls
  assign rd_first  = dp_act_r & ~dp_write_r & ~rd_wait_r;
  assign hreadyout = ~rd_first;
  assign hresp     = 1'b0;
  assign wr_en     = dp_act_r & dp_write_r;

  // ========================================================================
  // Register write decode
  assign wr_status = reg_hit(wr_en, dp_addr_r, `OFS_IRQ_STATUS);
  assign wr_mask   = reg_hit(wr_en, dp_addr_r, `OFS_IRQ_MASK);
  assign wr_ctl    = reg_hit(wr_en, dp_addr_r, `OFS_CRC_CONTROL);
  assign wr_crc    = reg_hit(wr_en, dp_addr_r, `OFS_CRC_VALUE);

  // ========================================================================
  // Read multiplexer
  // Software view of the generator state
  assign crc_out = ~bit_reverse(crc.state);

  // Unmapped offsets and reserved bits read zero
  always_comb begin
    rd_mux = '0;
    unique case (dp_addr_r)
      `OFS_IRQ_STATUS:  rd_mux[`IRQ_W-1:0] = irq_status_r;
      `OFS_IRQ_MASK:    rd_mux[`IRQ_W-1:0] = irq_mask_r;
      `OFS_CRC_CONTROL: rd_mux[`CTL_W-1:0] = ctl_r;
      `OFS_CRC_VALUE:   rd_mux             = crc_out;
      `OFS_POST_STATUS: rd_mux[`PST_W-1:0] = pst_r;
      default:          rd_mux             = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_first) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata = hrdata_r;

  // ========================================================================
  // Interrupt enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= `RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_r[`IRQ_BIT_DONE]    <= hwdata[`IRQ_BIT_DONE];
      irq_mask_r[`IRQ_BIT_FLOW]    <= hwdata[`IRQ_BIT_FLOW];
      irq_mask_r[`IRQ_BIT_BUS_ERR] <= hwdata[`IRQ_BIT_BUS_ERR];
    end
  end

  // ========================================================================
  // Sticky status flags, write one to clear, set wins
  always_comb begin
    irq_set                   = '0;
    irq_set[`IRQ_BIT_DONE]    = end_limit & ~end_periph_term;
    irq_set[`IRQ_BIT_FLOW]    = flow_overflow;
    irq_set[`IRQ_BIT_BUS_ERR] = bus_error;
  end

  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_status) begin
      irq_status_nxt = irq_status_r & ~hwdata[`IRQ_W-1:0];
    end
    irq_status_nxt = irq_status_nxt | irq_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= `RST_IRQ;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  assign irq_pend = irq_status_r & irq_mask_r;
  assign irq      = |irq_pend;

  // ========================================================================
  // Checksum control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= `RST_CTL;
    end else if (wr_ctl) begin
      ctl_r <= hwdata[`CTL_W-1:0];
    end
  end

  // ========================================================================
  // Generator feed
  assign crc.load       = wr_crc;
  assign crc.load_value = hwdata;
  assign crc.step       = ctl_r[`CTL_BIT_CALC_EN] & data_valid;
  assign crc.word       = data_word;

  // ========================================================================
  // Checksum append sequencer
  // Any end of transaction, normal or forced
  assign xfer_end = end_limit | end_periph_term | end_fw_abort | bus_error;
  assign post_go  = ctl_r[`CTL_BIT_POST_EN] & end_limit
                  & ~end_fw_abort & ~bus_error
                  & ~end_periph_term;
  assign post_fin   = (post_state_r == POST_SEND) & post_ready;
  assign post_start = (post_state_r == POST_IDLE) & post_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_state_r <= POST_IDLE;
    end else begin
      unique case (post_state_r)
        POST_IDLE: begin
          if (post_go) begin
            post_state_r <= POST_SEND;
          end
        end
        POST_SEND: begin
          if (post_ready) begin
            post_state_r <= POST_IDLE;
          end
        end
      endcase
    end
  end

  // Append word frozen at the end edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_data_r <= '0;
    end else if (post_start) begin
      post_data_r <= crc_out;
    end
  end

  assign post_valid = (post_state_r == POST_SEND);
  assign post_data  = post_data_r;

  // ========================================================================
  // Post status: set wins over clear by a new transfer
  // Set and clear requests per bit
  always_comb begin
    pst_set = '0;
    pst_clr = '0;
    if (xfer_start) begin
      pst_clr[`PST_BIT_DATA_DONE] = 1'b1;
      pst_clr[`PST_BIT_CRC_DONE]  = 1'b1;
    end
    if (xfer_end) begin
      pst_set[`PST_BIT_CRC_DONE] = 1'b1;
    end
    if (post_start) begin
      pst_set[`PST_BIT_RUNNING]    = 1'b1;
      pst_set[`PST_BIT_DATA_READY] = 1'b1;
    end
    if (post_fin) begin
      pst_clr[`PST_BIT_RUNNING]    = 1'b1;
      pst_clr[`PST_BIT_DATA_READY] = 1'b1;
      pst_set[`PST_BIT_DATA_DONE]  = 1'b1;
    end
  end

  assign pst_nxt = (pst_r & ~pst_clr) | pst_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r <= `RST_PST;
    end else begin
      pst_r <= pst_nxt;
    end
  end

endmodule : dma_channel_crc_and_irq_enable

// >>> dma_crc_monitor.sv
// Port checker for the channel checksum and interrupt block
`include "dma_crc_params.svh"
module dma_crc_monitor (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire dma_crc_pkg::addr_t haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire dma_crc_pkg::word_t hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               end_limit,
  input wire logic               end_periph_term,
  input wire logic               end_fw_abort,
  input wire logic               bus_error,
  input wire logic               flow_overflow,
  input wire logic               post_valid,
  input wire dma_crc_pkg::word_t post_data,
  input wire logic               post_ready,
  input wire logic               irq
);
  import dma_crc_pkg::*;
  logic       wp;
  logic       wr;
  logic       stop;
  addr_t      ad;
  logic [2:0] mk_r;
  logic [2:0] st_r;
  logic [1:0] ct_r;
  assign wr = wp && hready;
  assign stop = end_fw_abort || bus_error || end_periph_term;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of mask, control and status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'h0;
      ad <= '0;
      mk_r <= '0;
      ct_r <= '0;
      st_r <= '0;
    end else begin
      if (hready) begin
        wp <= hsel && htrans[1] && hwrite;
        ad <= haddr;
      end
      if (wr && ad == `OFS_IRQ_MASK) mk_r <= hwdata[2:0];
      if (wr && ad == `OFS_CRC_CONTROL) ct_r <= hwdata[1:0];
      st_r <= {end_limit && !end_periph_term, flow_overflow, bus_error}
            | (st_r & ~((wr && ad == `OFS_IRQ_STATUS) ? hwdata[2:0] : 3'h0));
    end
  end
  irq_or_mask_a: assert property (irq == |(st_r & mk_r))
    else $error("irq differs from enabled flags");
  done_irq_a: assert property (end_limit && !end_periph_term |=> irq || !mk_r[2])
    else $error("completion did not raise irq");
  flow_irq_a: assert property (flow_overflow |=> irq || !mk_r[1])
    else $error("overflow did not raise irq");
  fault_irq_a: assert property (bus_error |=> irq || !mk_r[0])
    else $error("bus fault did not raise irq");
  read_wait_a: assert property (hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  append_go_a: assert property (end_limit && ct_r[1] && !stop && !post_valid |=> post_valid)
    else $error("append not offered");
  append_skip_a: assert property (stop && !post_valid |=> !post_valid)
    else $error("append after abnormal end");
  post_hold_a: assert property (post_valid && !post_ready |=> post_valid && $stable(post_data))
    else $error("append word not held");
  post_done_a: assert property (post_valid && post_ready |=> !post_valid)
    else $error("append word not released");
  cover property (post_valid && !post_ready);
  cover property (irq);
  cover property (hready && hsel && htrans[1] && !hwrite);
endmodule : dma_crc_monitor

bind dma_channel_crc_and_irq_enable dma_crc_monitor mon (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .end_limit, .end_periph_term,
  .end_fw_abort, .bus_error, .flow_overflow, .post_valid, .post_data, .post_ready, .irq);

// >>> dma_crc_params.svh
// Register offsets, field positions, reset values and constants of the channel add-on
`ifndef DMA_CRC_PARAMS_SVH
`define DMA_CRC_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_IRQ_STATUS      8'h14
`define OFS_IRQ_MASK        8'h18
`define OFS_CRC_CONTROL     8'h20
`define OFS_CRC_VALUE       8'h24
`define OFS_POST_STATUS     8'h28
`define ADDR_W              8

// ==========================================================================
// Interrupt status and mask bits
`define IRQ_BIT_DONE        2
`define IRQ_BIT_FLOW        1
`define IRQ_BIT_BUS_ERR     0
`define IRQ_W               3
`define IRQ_MASK_REG_W      8

// ==========================================================================
// Checksum control bits
`define CTL_BIT_POST_EN     1
`define CTL_BIT_CALC_EN     0
`define CTL_W               2

// ==========================================================================
// Post status bits
`define PST_BIT_DATA_READY  3
`define PST_BIT_DATA_DONE   2
`define PST_BIT_RUNNING     1
`define PST_BIT_CRC_DONE    0
`define PST_W               4

// ==========================================================================
// Reset values and generator constants
`define RST_IRQ             3'h0
`define RST_CTL             2'h0
`define RST_CRC             32'h0000_0000
`define RST_PST             4'h0
`define CRC_POLY            32'h04C1_1DB7
`define DATA_W              32

`endif

// >>> dma_crc_pkg.sv
// Types shared by the channel checksum and interrupt logic
`include "dma_crc_params.svh"

package dma_crc_pkg;

  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  typedef enum logic [0:0] {
    POST_IDLE,
    POST_SEND
  } post_state_e;

endpackage : dma_crc_pkg

// >>> tb_top.sv
// Self-checking bench for the channel checksum and interrupt block
`include "dma_crc_params.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_crc_pkg::*;
  logic       hclk = 1'h0;
  logic       hresetn = 1'h0;
  logic       hsel = 1'h0;
  logic       hwrite = 1'h0;
  logic       data_valid = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [5:0] ev = 6'h00;
  logic [3:0] stall = 4'h0;
  addr_t      haddr = '0;
  word_t      hwdata = '0;
  word_t      data_word = '0;
  logic       hreadyout, post_valid, post_ready, irq, hresp;
  word_t      hrdata, post_data, got, rd, s, v;
  int         n;
  int         mismatches = 0;
  int         checks = 0;
  always #5 hclk = ~hclk;
  dma_channel_crc_and_irq_enable DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .xfer_start(ev[5]), .data_valid, .data_word, .end_limit(ev[4]), .end_periph_term(ev[3]),
    .end_fw_abort(ev[2]), .bus_error(ev[1]), .flow_overflow(ev[0]), .post_valid,
    .post_data, .post_ready, .irq);
  chan_sink sink (.hclk, .hresetn, .stall, .post_valid, .post_data, .post_ready, .got, .n);
  function automatic word_t step(word_t c, word_t w);
    for (int i = 0; i < 32; i++) c = {c[30:0], 1'h0} ^ ((c[31] ^ w[i]) ? `CRC_POLY : 32'h0);
    return c;
  endfunction : step
  function automatic word_t vis(word_t c);
    word_t r;
    for (int i = 0; i < 32; i++) r[i] = ~c[31-i];
    return r;
  endfunction : vis
  task automatic ahb(input logic w, input addr_t a, input word_t d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
    `CHK("hresp", 1'h0, hresp);
    #1;
  endtask : ahb
  task automatic wr(input addr_t a, input word_t d);
    ahb(1'h1, a, d);
  endtask : wr
  task automatic rc(input addr_t a, input word_t e);
    ahb(1'h0, a, '0);
    `CHK("register", e, rd);
  endtask : rc
  task automatic pulse(input logic [5:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 6'h00;
    #1;
  endtask : pulse
  task automatic feed(input word_t w, input logic en);
    @(posedge hclk);
    data_valid <= 1'h1;
    data_word <= w;
    @(posedge hclk);
    data_valid <= 1'h0;
    if (en) s = step(s, w);
  endtask : feed
  task automatic t_reset();
    rc(`OFS_IRQ_MASK, '0);
    rc(`OFS_CRC_CONTROL, '0);
    rc(`OFS_CRC_VALUE, 32'hFFFF_FFFF);
    rc(8'h40, '0);
  endtask : t_reset
  task automatic t_irq();
    logic [5:0] src [3];
    src = '{6'h02, 6'h01, 6'h10};
    for (int b = 0; b < 3; b++) begin
      wr(`OFS_IRQ_MASK, 32'h7 ^ (32'h1 << b));
      pulse(src[b]);
      `CHK("irq masked", 1'h0, irq);
      wr(`OFS_IRQ_MASK, 32'h1 << b);
      `CHK("irq raised", 1'h1, irq);
      wr(`OFS_IRQ_STATUS, 32'h1 << b);
      `CHK("irq cleared", 1'h0, irq);
    end
    wr(`OFS_IRQ_MASK, 32'h4);
    pulse(6'h18);
    `CHK("irq periph end", 1'h0, irq);
    rc(`OFS_IRQ_MASK, 32'h4);
  endtask : t_irq
  task automatic t_crc();
    wr(`OFS_CRC_CONTROL, 32'h1);
    wr(`OFS_CRC_VALUE, 32'hFFFF_FFFF);
    s = 32'hFFFF_FFFF;
    feed(32'h0000_0000, 1'h1);
    rc(`OFS_CRC_VALUE, 32'h2144_DF1C);
    feed(32'h1234_5678, 1'h1);
    feed(32'h0000_0000, 1'h1);
    rc(`OFS_CRC_VALUE, vis(s));
    wr(`OFS_CRC_CONTROL, 32'h0);
    feed(32'hA5A5_A5A5, 1'h0);
    rc(`OFS_CRC_VALUE, vis(s));
    wr(`OFS_CRC_CONTROL, 32'h1);
    pulse(6'h20);
    feed(32'hDEAD_BEEF, 1'h1);
    rc(`OFS_CRC_VALUE, vis(s));
    v = rd;
    wr(`OFS_CRC_VALUE, 32'h0);
    wr(`OFS_CRC_VALUE, vis(v));
    rc(`OFS_CRC_VALUE, v);
  endtask : t_crc
  task automatic t_post();
    wr(`OFS_CRC_CONTROL, 32'h3);
    stall <= 4'hF;
    pulse(6'h20);
    rc(`OFS_POST_STATUS, '0);
    pulse(6'h10);
    `CHK("append offered", 1'h1, post_valid);
    rc(`OFS_POST_STATUS, 32'hB);
    for (int i = 0; i < 20 && n == 0; i++) @(posedge hclk);
    #1;
    `CHK("append word", vis(s), got);
    rc(`OFS_POST_STATUS, 32'h5);
    for (int i = 0; i < 3; i++) begin
      pulse(6'h10 | (6'h02 << i));
      `CHK("append skipped", 1'h0, post_valid);
    end
    rc(`OFS_IRQ_STATUS, 32'h5);
    pulse(6'h20);
    rc(`OFS_POST_STATUS, '0);
    pulse(6'h04);
    rc(`OFS_POST_STATUS, 32'h1);
  endtask : t_post
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_irq();
    t_crc();
    t_post();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
